// *** verilog/adc_seq_pkg.sv ***
// Contract
// - Module enable set runs the converter; cleared turns the converter off.
// - Idle stop set halts operation in Idle mode; cleared keeps running.
// - Build mode set gives stand-alone buffer addresses; cleared gives scatter/gather addresses.
// - Resolution select set is 12-bit one channel; cleared is 10-bit four channels.
// - 10-bit format 00 zero-extends; 01 fills bits 15..9 with inverted bit 9.
// - 12-bit format 00 zero-extends; 01 fills upper bits with inverted bit 11.
// - Trigger 111 sample counter, 001 pin edge, 000 software clearing sample bit.
// - Trigger 100 and 010 use timer compare events of two timers.
// - Simultaneous sample groups channels per channel count; absent in 12-bit mode.
// - Auto-sample starts sampling right after conversion and sets sample bit.
// - Software sets sample bit; code 000 software ends it; else hardware clears.
// - Completion flag set at end, cleared at start; software only clears it.
// - Reference field selects supply, ground or external references per code.
// - Scan enable steps channel 0 input through scan list during Sample A.
// - Channel count converts 0-3, 0-1 or 0; reads zero in 12-bit mode.
// - Buffer half status reads one while second half fills, zero for first.
// - Increment rate N gives address step or event every N+1 operations.
// - Split buffer alternates halves per event; otherwise restart at buffer start.
// - Alternate input mode alternates Sample A and Sample B selections.
// - Clock source bit selects RC oscillator when set, system clock otherwise.
// - Auto sample time sets 0 to 31 conversion clocks, used with code 111.
// - Divider sets conversion clock to instruction cycles times field plus one.
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // Register map and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL_ONE   = 8'h00;
  localparam logic [7:0]  ADDR_CTRL_TWO   = 8'h04;
  localparam logic [7:0]  ADDR_CTRL_THREE = 8'h08;
  localparam logic [7:0]  ADDR_RESULT     = 8'h0C;
  localparam logic [15:0] CTRL_ONE_WMASK   = 16'hB7EC;
  localparam logic [15:0] CTRL_TWO_WMASK   = 16'hE73F;
  localparam logic [15:0] CTRL_THREE_WMASK = 16'h9FFF;
  localparam logic [15:0] CTRL_RESET       = 16'h0000;
  localparam int          SAMPLE_BIT_POS   = 1;
  localparam int          DONE_BIT_POS     = 0;
  localparam int          CONV_TADS_DEF    = 12;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] TRIG_SOFT  = 3'h0;
  localparam logic [2:0] TRIG_PIN   = 3'h1;
  localparam logic [2:0] TRIG_TMR_B = 3'h2;
  localparam logic [2:0] TRIG_TMR_A = 3'h4;
  localparam logic [2:0] TRIG_AUTO  = 3'h7;
  localparam logic [1:0] FMT_SIGNED = 2'h1;
  localparam logic [2:0] REF_EXT_P  = 3'h1;
  localparam logic [2:0] REF_EXT_N  = 3'h2;
  localparam logic [2:0] REF_EXT_PN = 3'h3;

  typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_t;

  typedef struct packed {
    logic       module_enable;
    logic       rsv14;
    logic       idle_stop;
    logic       dma_build_mode;
    logic       rsv11;
    logic       resolution_select;
    logic [1:0] output_format;
    logic [2:0] trigger_source;
    logic       rsv4;
    logic       simultaneous_sample;
    logic       auto_sample_start;
    logic       sample_bit;
    logic       done;
  } ctrl_one_t;

  typedef struct packed {
    logic [2:0] reference_config;
    logic [1:0] rsv12;
    logic       scan_enable;
    logic [1:0] channel_count;
    logic       buffer_half_status;
    logic       rsv6;
    logic [3:0] increment_rate;
    logic       split_buffer_mode;
    logic       alternate_input_mode;
  } ctrl_two_t;

  typedef struct packed {
    logic       conv_clock_source;
    logic [1:0] rsv13;
    logic [4:0] auto_sample_time;
    logic [7:0] conv_clock_divider;
  } ctrl_three_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  channel;
    logic [15:0] data;
  } result_t;

endpackage

// *** verilog/adc_sequencing_control.sv ***
`timescale 1ns/10ps
module adc_sequencing_control
  import adc_seq_pkg::*;
#(
  parameter int CONV_TADS      = CONV_TADS_DEF,
  parameter int ADDR_W         = 8,
  parameter int WORDS_LOG2     = 2,
  parameter int BUF_DEPTH_LOG2 = 4
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              idle_mode,
  input  wire logic              external_interrupt_pin0,
  input  wire logic              timer_a_match,
  input  wire logic              timer_b_match,
  input  wire logic              rc_osc_clock,
  input  wire logic [11:0]       conv_data,
  output logic                   module_on,
  output logic [3:0]             sample_hold,
  output logic                   converting,
  output logic                   sample_b_sel,
  output logic                   scan_step,
  output logic                   vref_pos_ext,
  output logic                   vref_neg_ext,
  output result_t                result,
  output logic [ADDR_W-1:0]      dma_addr,
  output logic                   seq_event
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ctrl_one_t        c1_q;
  ctrl_two_t        c2_q;
  ctrl_three_t      c3_q;
  seq_state_t       state_q;
  logic             ap_wr_q, ap_rd_q;
  logic [7:0]       ap_addr_q;
  logic             pin_meta_q, pin_sync_q, pin_prev_q;
  logic             rc_meta_q, rc_sync_q, rc_prev_q;
  logic [7:0]       div_cnt_q;
  logic [4:0]       sample_bit_cnt_q;
  logic [7:0]       tad_cnt_q;
  logic [1:0]       ch_q;
  logic             done_q;
  logic [3:0]       op_cnt_q;
  logic [BUF_DEPTH_LOG2-1:0] buf_ptr_q;
  logic [WORDS_LOG2-1:0]     word_idx_q;
  logic             half_q;
  logic             use_b_q;
  logic             run, tad_tick, wr_c1, sw_start, sw_end, end_sample;
  logic             conv_start, res_done, seq_end, rate_hit, res12, simultaneous_sample_eff;
  logic [1:0]       last_ch, chps_eff;
  logic [3:0]       sample_bit_mask;
  logic [15:0]      rd_val;
  ctrl_one_t        c1_view;
  ctrl_two_t        c2_view;

  // Result formatting used by the result path only; the checks compute their own
  function automatic logic [15:0] fmt_result(input logic [11:0] d, input logic r12,
                                             input logic [1:0] form);
    if (r12) begin
      fmt_result = (form == FMT_SIGNED) ? {{5{~d[11]}}, d[10:0]} : {4'h0, d};
    end else begin
      fmt_result = (form == FMT_SIGNED) ? {{7{~d[9]}}, d[8:0]} : {6'h00, d[9:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Address phase capture; reads take one wait state so write data lands first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q   <= 1'b0;
      ap_rd_q   <= 1'b0;
      ap_addr_q <= 8'h00;
    end else if (hready) begin
      ap_wr_q   <= hsel & htrans[1] & hwrite;
      ap_rd_q   <= hsel & htrans[1] & ~hwrite;
      ap_addr_q <= haddr[7:0];
    end else begin
      ap_rd_q   <= 1'b0;
    end
  end

  // Ready low for the first read data cycle, read data loaded then
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (ap_rd_q) begin
        hreadyout <= 1'b1;
        hrdata    <= {16'h0000, rd_val};
      end
    end
  end

  // Read views: hardware-owned bits and 12-bit unimplemented fields
  always_comb begin
    c1_view                     = c1_q;
    c1_view.simultaneous_sample = c1_q.simultaneous_sample & ~res12;
    c1_view.sample_bit          = (state_q == ST_SAMPLE);
    c1_view.done                = done_q;
    c2_view                     = c2_q;
    c2_view.channel_count       = chps_eff;
    c2_view.buffer_half_status  = half_q;
    case (ap_addr_q)
      ADDR_CTRL_ONE:   rd_val = c1_view;
      ADDR_CTRL_TWO:   rd_val = c2_view;
      ADDR_CTRL_THREE: rd_val = c3_q;
      ADDR_RESULT:     rd_val = result.data;
      default:         rd_val = 16'h0000;
    endcase
  end

  assign wr_c1 = ap_wr_q && (ap_addr_q == ADDR_CTRL_ONE);

  // Control registers; only writable bits are stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c1_q <= ctrl_one_t'(CTRL_RESET);
      c2_q <= ctrl_two_t'(CTRL_RESET);
      c3_q <= ctrl_three_t'(CTRL_RESET);
    end else if (ap_wr_q) begin
      if (ap_addr_q == ADDR_CTRL_ONE) c1_q <= ctrl_one_t'(hwdata[15:0] & CTRL_ONE_WMASK);
      if (ap_addr_q == ADDR_CTRL_TWO) c2_q <= ctrl_two_t'(hwdata[15:0] & CTRL_TWO_WMASK);
      if (ap_addr_q == ADDR_CTRL_THREE) begin
        c3_q <= ctrl_three_t'(hwdata[15:0] & CTRL_THREE_WMASK);
      end
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers and conversion clock
  // ----------------------------------------------------------------
  // Pin and RC oscillator cross in through two flops each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
      rc_meta_q  <= 1'b0;
      rc_sync_q  <= 1'b0;
      rc_prev_q  <= 1'b0;
    end else begin
      pin_meta_q <= external_interrupt_pin0;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      rc_meta_q  <= rc_osc_clock;
      rc_sync_q  <= rc_meta_q;
      rc_prev_q  <= rc_sync_q;
    end
  end

  assign run      = c1_q.module_enable & ~(c1_q.idle_stop & idle_mode);
  assign res12    = c1_q.resolution_select;
  assign chps_eff = res12 ? 2'h0 : c2_q.channel_count;
  assign simultaneous_sample_eff = c1_q.simultaneous_sample & ~res12;
  assign last_ch  = chps_eff[1] ? 2'h3 : {1'b0, chps_eff[0]};
  // RC edge or divided system clock; the RC rate must stay well below hclk/2
  assign tad_tick = c3_q.conv_clock_source ? (rc_sync_q & ~rc_prev_q)
                                           : (div_cnt_q == c3_q.conv_clock_divider);

  // Divider: one hclk per instruction cycle, period field plus one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= 8'h00;
    end else if (!run || div_cnt_q == c3_q.conv_clock_divider) begin
      div_cnt_q <= 8'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign sw_start = wr_c1 && hwdata[SAMPLE_BIT_POS] && !c1_q.auto_sample_start;
  assign sw_end   = wr_c1 && !hwdata[SAMPLE_BIT_POS];

  // Trigger selection; reserved codes never end sampling
  always_comb begin
    case (c1_q.trigger_source)
      TRIG_SOFT:  end_sample = sw_end;
      TRIG_PIN:   end_sample = pin_sync_q & ~pin_prev_q;
      TRIG_TMR_A: end_sample = timer_a_match;
      TRIG_TMR_B: end_sample = timer_b_match;
      TRIG_AUTO:  end_sample = (sample_bit_cnt_q == c3_q.auto_sample_time);
      default:    end_sample = 1'b0;
    endcase
  end

  assign conv_start = run && (state_q == ST_SAMPLE) && end_sample;
  assign res_done   = run && (state_q == ST_CONVERT) && tad_tick &&
                      (tad_cnt_q == 8'(CONV_TADS - 1));
  assign seq_end    = res_done && (ch_q == last_ch);
  assign rate_hit   = seq_end && (op_cnt_q == c2_q.increment_rate);

  // Main state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_OFF;
    end else if (!run) begin
      state_q <= ST_OFF;
    end else begin
      case (state_q)
        ST_OFF:     state_q <= ST_IDLE;
        ST_IDLE: begin
          if (c1_q.auto_sample_start || sw_start) state_q <= ST_SAMPLE;
        end
        ST_SAMPLE: begin
          if (end_sample) state_q <= ST_CONVERT;
        end
        ST_CONVERT: begin
          if (seq_end) state_q <= c1_q.auto_sample_start ? ST_SAMPLE : ST_IDLE;
        end
        default:    state_q <= ST_OFF;
      endcase
    end
  end

  // Sample time counter in conversion clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_bit_cnt_q <= 5'h00;
    end else if (state_q != ST_SAMPLE || end_sample) begin
      sample_bit_cnt_q <= 5'h00;
    end else if (tad_tick && sample_bit_cnt_q != c3_q.auto_sample_time) begin
      sample_bit_cnt_q <= sample_bit_cnt_q + 5'h01;
    end
  end

  // Per-result conversion clocks and channel index
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tad_cnt_q <= 8'h00;
      ch_q      <= 2'h0;
    end else if (state_q != ST_CONVERT) begin
      tad_cnt_q <= 8'h00;
      ch_q      <= 2'h0;
    end else if (res_done) begin
      tad_cnt_q <= 8'h00;
      ch_q      <= seq_end ? 2'h0 : ch_q + 2'h1;
    end else if (tad_tick) begin
      tad_cnt_q <= tad_cnt_q + 8'h01;
    end
  end

  // Completion flag: hardware set wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (seq_end) begin
      done_q <= 1'b1;
    end else if (conv_start || (wr_c1 && !hwdata[DONE_BIT_POS])) begin
      done_q <= 1'b0;
    end
  end

  // Alternate Sample A/B selection, toggled at each end of sampling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      use_b_q <= 1'b0;
    end else if (!c2_q.alternate_input_mode || !run) begin
      use_b_q <= 1'b0;
    end else if (conv_start) begin
      use_b_q <= ~use_b_q;
    end
  end

  // ----------------------------------------------------------------
  // Buffer pointers and event rate
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_cnt_q   <= 4'h0;
      buf_ptr_q  <= '0;
      word_idx_q <= '0;
      half_q     <= 1'b0;
    end else if (!run) begin
      op_cnt_q   <= 4'h0;
      buf_ptr_q  <= '0;
      word_idx_q <= '0;
      half_q     <= 1'b0;
    end else begin
      if (!c2_q.split_buffer_mode) half_q <= 1'b0;
      if (rate_hit) begin
        op_cnt_q   <= 4'h0;
        word_idx_q <= word_idx_q + WORDS_LOG2'(1);
        if (c2_q.split_buffer_mode) begin
          half_q    <= ~half_q;
          buf_ptr_q <= {~half_q, {(BUF_DEPTH_LOG2-1){1'b0}}};
        end else begin
          buf_ptr_q <= '0;
        end
      end else begin
        if (seq_end) op_cnt_q <= op_cnt_q + 4'h1;
        if (res_done) buf_ptr_q <= buf_ptr_q + BUF_DEPTH_LOG2'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Channels still tracking: all up to last_ch in sampling, unconverted ones if sequential
  generate
    for (genvar k = 0; k < 4; k++) begin : g_hold
      assign sample_bit_mask[k] = (2'(k) <= last_ch) &&
                            ((state_q == ST_SAMPLE) ||
                             (state_q == ST_CONVERT && !simultaneous_sample_eff && 2'(k) > ch_q));
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_on    <= 1'b0;
      sample_hold  <= 4'h0;
      converting   <= 1'b0;
      sample_b_sel <= 1'b0;
      scan_step    <= 1'b0;
      vref_pos_ext <= 1'b0;
      vref_neg_ext <= 1'b0;
    end else begin
      module_on    <= run;
      sample_hold  <= sample_bit_mask;
      converting   <= (state_q == ST_CONVERT);
      sample_b_sel <= use_b_q;
      scan_step    <= conv_start && c2_q.scan_enable && !use_b_q;
      vref_pos_ext <= (c2_q.reference_config == REF_EXT_P) ||
                      (c2_q.reference_config == REF_EXT_PN);
      vref_neg_ext <= (c2_q.reference_config == REF_EXT_N) ||
                      (c2_q.reference_config == REF_EXT_PN);
    end
  end

  // Result word and its DMA address, one pulse per converted channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result    <= '0;
      dma_addr  <= '0;
      seq_event <= 1'b0;
    end else begin
      result.valid <= res_done;
      seq_event    <= rate_hit;
      if (res_done) begin
        result.channel <= ch_q;
        result.data    <= fmt_result(conv_data, res12, c1_q.output_format);
        if (c1_q.dma_build_mode) begin
          dma_addr <= ADDR_W'(buf_ptr_q);
        end else begin
          dma_addr <= ADDR_W'({ch_q, word_idx_q});
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_done_sets:    assert property (seq_end |=> done_q && result.valid)
    else $error("completion flag not set after last result");
  a_done_clears:  assert property (conv_start |=> !done_q)
    else $error("completion flag not cleared at conversion start");
  a_off_state:    assert property (!c1_q.module_enable
                                   |=> state_q == ST_OFF && !module_on)
    else $error("sequencer running while disabled");
  a_idle_halt:    assert property (run ##1 (c1_q.idle_stop && idle_mode) |=> !module_on)
    else $error("converter not halted in idle");
  a_soft_end:     assert property (state_q == ST_SAMPLE && run && c1_q.trigger_source == TRIG_SOFT
                                   && sw_end |=> state_q == ST_CONVERT)
    else $error("software clear did not start conversion");
  a_auto_rearm:   assert property (seq_end && c1_q.auto_sample_start && run
                                   |=> state_q == ST_SAMPLE)
    else $error("auto sample did not restart sampling");
  a_zero_ext:     assert property (res_done && c1_q.output_format == 2'h0 && !res12
                                   |=> result.data[15:10] == 6'h00)
    else $error("10-bit integer result not zero extended");
  a_signed_fill:  assert property (res_done && c1_q.output_format == FMT_SIGNED && res12
                                   |=> result.data[15:11] == {5{~$past(conv_data[11])}})
    else $error("12-bit signed fill wrong");
  a_single_chan:  assert property (state_q == ST_CONVERT && res12 |-> ch_q == 2'h0)
    else $error("12-bit mode converted more than one channel");
  a_ext_refs:     assert property (c2_q.reference_config == REF_EXT_PN
                                   |=> vref_pos_ext && vref_neg_ext)
    else $error("external reference pair not selected");

  c_four_chan:  cover property (seq_end && last_ch == 2'h3 && simultaneous_sample_eff);
  c_split_flip: cover property (rate_hit && c2_q.split_buffer_mode ##1 half_q);
  c_auto_conv:  cover property (conv_start && c1_q.trigger_source == TRIG_AUTO);

endmodule

// *** tb/adc_analog_model.sv ***
`timescale 1ns/10ps
// ----
// Analog side: RC oscillator and converter core
// ----
module adc_analog_model #(
  parameter logic [11:0] VALUE = 12'h2A5
) (
  input  wire logic        hclk,
  input  wire logic        converting,
  output logic             rc_osc_clock,
  output logic [11:0]      conv_data
);
  logic conv_q = 1'b0;
  logic flip   = 1'b0;
  // RC oscillator runs free, unrelated in phase to hclk
  initial begin
    rc_osc_clock = 1'b0;
    forever #37 rc_osc_clock = ~rc_osc_clock;
  end
  // Code holds only around a conversion, so a stale read shows up
  always @(posedge hclk) begin
    conv_q <= converting;
    flip   <= ~flip;
  end
  assign conv_data = (converting || conv_q) ? VALUE : {12{flip}};
endmodule

// *** tb/test_adc_sequencing_control.sv ***
`timescale 1ns/10ps
// ----
// Bench: register access and one conversion per row
// ----
module test_adc_sequencing_control
  import adc_seq_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin, tma, tmb, rc, conv, vp, vn;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [11:0] conv_data;
  logic        idle, module_on, seq_event;
  logic [7:0]  dma;
  logic [3:0]  sample_hold;
  result_t     result;
  int          failures = 0;
  int          n_compared = 0;
  // Rows: address, write value, read-back value
  logic [15:0] regs [5][3] = '{'{16'h4, 16'hFFFF, 16'hE73F}, '{16'h8, 16'hFFFF, 16'h9FFF},
    '{16'h10, 16'hFFFF, 16'h0}, '{16'h4, 16'h6000, 16'h6000}, '{16'h8, 16'h0, 16'h0}};
  // Rows: control one word, expected result for a code of 12'h2A5
  logic [15:0] rows [4][2] = '{'{16'h8000, 16'h02A5}, '{16'h8120, 16'h00A5},
    '{16'h8480, 16'h02A5}, '{16'h8540, 16'hFAA5}};

  adc_sequencing_control uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .idle_mode(idle),
    .external_interrupt_pin0(pin), .timer_a_match(tma), .timer_b_match(tmb),
    .rc_osc_clock(rc), .conv_data(conv_data), .module_on(module_on),
    .sample_hold(sample_hold), .converting(conv), .sample_b_sel(), .scan_step(),
    .vref_pos_ext(vp), .vref_neg_ext(vn), .result(result), .dma_addr(dma),
    .seq_event(seq_event));
  adc_analog_model partner (.hclk(hclk), .converting(conv), .rc_osc_clock(rc),
    .conv_data(conv_data));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Edge with hready high, bounded so a stuck slave ends the run
  task automatic edge_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      stop_test();
    end
  endtask

  task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {16'h0, a};
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    edge_rdy();
    rd = hrdata;
    check("hresp", 16'h0, {15'h0, hresp});
  endtask

  // Off, on, sample, then the trigger picked by the row's code
  task automatic convert(input logic [15:0] c1, input logic [15:0] exp);
    int k;
    bus(1, ADDR_CTRL_ONE, c1 & 16'h7FFF);
    bus(1, ADDR_CTRL_ONE, c1);
    bus(1, ADDR_CTRL_ONE, c1 | 16'h0002);
    repeat (3) @(posedge hclk);
    case (c1[7:5])
      3'h0: bus(1, ADDR_CTRL_ONE, c1);
      3'h1: pin <= 1'b1;
      3'h4: tma <= 1'b1;
      default: tmb <= 1'b1;
    endcase
    @(posedge hclk);
    tma <= 1'b0;
    tmb <= 1'b0;
    k = 0;
    while (result.valid !== 1'b1 && k < 2000) begin
      @(posedge hclk);
      k++;
    end
    pin <= 1'b0;
    check("valid", 16'h1, {15'h0, result.valid});
    check("module_on", 16'h1, {15'h0, module_on});
    check("data", exp, result.data);
    bus(0, ADDR_CTRL_ONE, 16'h0);
    check("ctrl1", c1 | 16'h0001, rd[15:0]);
    // Leave disabled so the next row may change resolution safely
    bus(1, ADDR_CTRL_ONE, c1 & 16'h7FFF);
    repeat (2) @(posedge hclk);
    check("module_on", 16'h0, {15'h0, module_on});
  endtask

  initial begin
    int k;
    hresetn = 1'b0;
    idle    = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    pin     = 1'b0;
    tma     = 1'b0;
    tmb     = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 12; i += 4) begin
      bus(0, i[15:0], 16'h0);
      check("reset", CTRL_RESET, rd[15:0]);
    end
    for (int i = 0; i < 5; i++) begin
      bus(1, regs[i][0], regs[i][1]);
      bus(0, regs[i][0], 16'h0);
      check("reg", regs[i][2], rd[15:0]);
      if (i == 0) check("vref", 16'h0, {14'h0, vp, vn});
    end
    check("vref", 16'h3, {14'h0, vp, vn});
    foreach (rows[i]) convert(rows[i][0], rows[i][1]);
    // Writing one to done is ignored, zero clears it
    bus(1, ADDR_CTRL_ONE, 16'h8400);
    bus(1, ADDR_CTRL_ONE, 16'h8401);
    bus(0, ADDR_CTRL_ONE, 16'h0);
    check("done", 16'h8400, rd[15:0]);
    // Idle with stop set halts the converter; with stop clear it keeps running
    bus(1, ADDR_CTRL_ONE, 16'hA400);
    idle <= 1'b1;
    repeat (3) @(posedge hclk);
    check("module_on", 16'h0, {15'h0, module_on});
    bus(1, ADDR_CTRL_ONE, 16'h8400);
    repeat (2) @(posedge hclk);
    check("module_on", 16'h1, {15'h0, module_on});
    // Auto sample on the RC clock, four channels, event every second sequence
    bus(1, ADDR_CTRL_ONE, 16'h0400);
    bus(1, ADDR_CTRL_ONE, 16'h00E4);
    bus(1, ADDR_CTRL_TWO, 16'h6204);
    bus(1, ADDR_CTRL_THREE, 16'h8200);
    bus(1, ADDR_CTRL_ONE, 16'h80E4);
    for (int n = 0; n < 8; n++) begin
      k = 0;
      do begin
        @(posedge hclk);
        k++;
      end while (result.valid !== 1'b1 && k < 200);
      check("valid", 16'h1, {15'h0, result.valid});
      check("rc pace", 16'h1, {15'h0, k > 30});
      check("data", 16'h02A5, result.data);
      check("chan", 16'(n % 4), {14'h0, result.channel});
      check("hold", (16'hE << (n % 4)) & 16'hF, {12'h0, sample_hold});
      check("dma", 16'(4 * (n % 4)), {8'h0, dma});
      check("event", {15'h0, n == 7}, {15'h0, seq_event});
    end
    stop_test();
  end
endmodule
